/* rtl/servo_digital_input_functions.sv */
// Digital input function unit: filters, decodes and applies input functions
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Drive-enable input makes the drive servo-ready, gated by the servo-on setting.
// - Fault-clear input clears latched faults marked clearable.
// - Speed/position mode, gain switch 1, gain-boost input boosts gain.
// - Deviation-clear input runs the action the clear mode selects.
// - Deviation reset option, only in external pulse and internal position modes.
// - Feedback and rotation count reset, only in both position modes.
// - Abort option, internal position only: drop pulses, stop motion.
// - Abort-and-report option: stop, then raise target reached once stopped.
// - Standstill lock holds position while on and speed below threshold.
// - Direction invert reverses command in internal position, speed, torque modes.
// - Motion hold pauses internal position command until released.
// - Move trigger acts on rising edge only, internal position mode only.
// - Each trigger starts move to position indexed by select bits then.
// - Torque limit enable validates torque limit in speed and position modes.
// - Torque limit source is internal parameter or analog per configuration.
// - Speed limit enable validates speed limit in torque mode.
// - Speed limit source is internal parameter or analog per configuration.
// - Select inputs codes 11 to 13 form binary index of eight positions.
module servo_digital_input_functions
    import servo_input_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    input  wire logic [NUM_INPUTS-1:0]   input_lines,
    input  wire logic [NUM_INPUTS*4-1:0] input_codes,
    input  wire control_mode_type        control_mode,
    input  wire clear_mode_type          clear_mode_setting,
    input  wire logic [1:0]              gain_switch_setting,
    input  wire logic                    servo_on_setting,
    input  wire logic [15:0]             zero_speed_threshold,
    input  wire logic [15:0]             motor_speed,
    input  wire logic                    motor_stopped,
    input  wire logic                    fault_latched,
    input  wire logic                    fault_clearable,
    input  wire logic                    torque_source_analog,
    input  wire logic                    speed_source_analog,
    output var  motion_ctrl_type         ctrl,
    output var  logic                    fault_active,
    output var  logic                    target_reached_output
);

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning
    logic [NUM_INPUTS-1:0] clean_lines;
    input_funcs_type       funcs;

    for (genvar g = 0; g < NUM_INPUTS; g++)
    begin : g_filt
        input_filter u_filt
        (
            .clock     (clock),
            .sys_rst   (sys_rst),
            .clk_en    (clk_en),
            .raw_in    (input_lines[g]),
            .clean_out (clean_lines[g])
        );
    end

    func_decoder u_dec
    (
        .lines (clean_lines),
        .codes (input_codes),
        .funcs (funcs)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode qualifiers
    logic in_pos_mode;
    logic in_int_pos;
    logic in_speed_pos;
    logic in_torque;

    assign in_int_pos   = (control_mode == MODE_INT_POS);
    assign in_pos_mode  = (control_mode == MODE_INT_POS) || (control_mode == MODE_EXT_PULSE);
    assign in_speed_pos = in_pos_mode || (control_mode == MODE_SPEED);
    assign in_torque    = (control_mode == MODE_TORQUE);

    ////////////////////////////////////////////////////////////////////////
    // Edge and fault state
    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_STOPPING = 2'b01,
        ST_REACHED = 2'b10
    } abort_state_type;

    abort_state_type state_ff;
    abort_state_type nxt_state;
    logic            trig_prev_ff;
    logic            nxt_trig_prev;
    logic            clr_prev_ff;
    logic            nxt_clr_prev;
    logic            fault_ff;
    logic            nxt_fault;
    logic            trig_rise;
    logic            clr_rise;
    motion_ctrl_type ctrl_ff;
    motion_ctrl_type nxt_ctrl;

    assign trig_rise = funcs.move_trigger_input && !trig_prev_ff;
    assign clr_rise  = funcs.deviation_clear_input && !clr_prev_ff;

    always_comb
    begin
        nxt_trig_prev = funcs.move_trigger_input;
        nxt_clr_prev  = funcs.deviation_clear_input;
        nxt_state     = state_ff;
        nxt_fault     = fault_ff;
        // A new fault in the clear cycle must not be lost: set wins
        if (funcs.fault_clear_input && fault_clearable)
        begin
            nxt_fault = 1'b0;
        end
        if (fault_latched)
        begin
            nxt_fault = 1'b1;
        end
        unique case (state_ff)
            ST_IDLE:
            begin
                if (clr_rise && in_int_pos && clear_mode_setting == CLR_ABORT_REPORT)
                begin
                    nxt_state = ST_STOPPING;
                end
            end
            ST_STOPPING:
            begin
                if (motor_stopped)
                begin
                    nxt_state = ST_REACHED;
                end
            end
            ST_REACHED:
            begin
                // Report stands until the next move begins
                if (trig_rise && in_int_pos)
                begin
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Motion controller commands
    always_comb
    begin
        nxt_ctrl                       = '0;
        nxt_ctrl.servo_ready           = funcs.drive_enable_input && servo_on_setting;
        nxt_ctrl.fault_clear_pulse     = funcs.fault_clear_input && fault_clearable;
        nxt_ctrl.gain_boosted          = in_speed_pos && funcs.gain_boost_input
                                         && gain_switch_setting == GAIN_SWITCH_ON;
        // Clear acts once per activation, so a held input does not keep zeroing
        if (clr_rise)
        begin
            unique case (clear_mode_setting)
                CLR_DEVIATION:  nxt_ctrl.deviation_reset_pulse = in_pos_mode;
                CLR_FEEDBACK:   nxt_ctrl.feedback_reset_pulse  = in_pos_mode;
                CLR_ABORT:      nxt_ctrl.abort_motion_pulse    = in_int_pos;
                CLR_ABORT_REPORT: nxt_ctrl.abort_motion_pulse  = in_int_pos;
            endcase
        end
        nxt_ctrl.standstill_hold       = funcs.standstill_lock_input
                                         && motor_speed < zero_speed_threshold;
        nxt_ctrl.direction_inverted    = funcs.direction_invert_input
                                         && (in_int_pos || control_mode == MODE_SPEED
                                             || in_torque);
        nxt_ctrl.position_paused       = funcs.motion_hold_input && in_int_pos;
        nxt_ctrl.move_start_pulse      = trig_rise && in_int_pos;
        nxt_ctrl.move_index            = ctrl_ff.move_index;
        if (trig_rise && in_int_pos)
        begin
            // Relies on the controller holding select lines steady here
            nxt_ctrl.move_index = {funcs.position_select_bit2, funcs.position_select_bit1,
                                   funcs.position_select_bit0};
        end
        nxt_ctrl.torque_limit_active      = funcs.torque_limit_enable_input
                                            && in_speed_pos;
        nxt_ctrl.torque_limit_from_analog = torque_source_analog;
        nxt_ctrl.speed_limit_active       = funcs.speed_limit_enable_input && in_torque;
        nxt_ctrl.speed_limit_from_analog  = speed_source_analog;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff     <= ST_IDLE;
            trig_prev_ff <= FLAG_RESET;
            clr_prev_ff  <= FLAG_RESET;
            fault_ff     <= FLAG_RESET;
            ctrl_ff      <= '0;
        end
        else if (clk_en)
        begin
            state_ff     <= nxt_state;
            trig_prev_ff <= nxt_trig_prev;
            clr_prev_ff  <= nxt_clr_prev;
            fault_ff     <= nxt_fault;
            ctrl_ff      <= nxt_ctrl;
        end
    end

    assign ctrl                  = ctrl_ff;
    assign fault_active          = fault_ff;
    assign target_reached_output = (state_ff == ST_REACHED);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_trig_edge;
        clk_en && trig_rise && in_int_pos;
    endsequence

    sequence s_report_req;
        clk_en && clr_rise && in_int_pos && state_ff == ST_IDLE
            && clear_mode_setting == CLR_ABORT_REPORT;
    endsequence

    a_trigger_single: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && funcs.move_trigger_input && trig_prev_ff)
            |=> !ctrl_ff.move_start_pulse)
        else $error("held trigger level caused a repeat move");

    a_trigger_start: assert property (@(posedge clock) disable iff (sys_rst)
        s_trig_edge |=> ctrl_ff.move_start_pulse)
        else $error("accepted trigger did not start move");

    a_move_index: assert property (@(posedge clock) disable iff (sys_rst)
        s_trig_edge |=> ctrl_ff.move_index == $past({funcs.position_select_bit2,
            funcs.position_select_bit1, funcs.position_select_bit0}))
        else $error("move index not sampled at trigger");

    a_servo_ready: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !servo_on_setting) |=> !ctrl_ff.servo_ready)
        else $error("servo ready without servo-on setting");

    a_fault_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && fault_latched) |=> fault_ff)
        else $error("new fault lost during clear");

    a_gain_mode: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && (in_torque || gain_switch_setting != GAIN_SWITCH_ON))
            |=> !ctrl_ff.gain_boosted)
        else $error("gain boosted outside its conditions");

    a_clear_single: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && funcs.deviation_clear_input && clr_prev_ff)
            |=> !(ctrl_ff.deviation_reset_pulse || ctrl_ff.feedback_reset_pulse
                  || ctrl_ff.abort_motion_pulse))
        else $error("held clear repeated its action");

    a_clear_mode: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !in_pos_mode)
            |=> !(ctrl_ff.deviation_reset_pulse || ctrl_ff.feedback_reset_pulse))
        else $error("count reset outside position modes");

    a_abort_mode: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !in_int_pos) |=> !ctrl_ff.abort_motion_pulse)
        else $error("abort outside internal position mode");

    a_abort_report: assert property (@(posedge clock) disable iff (sys_rst)
        s_report_req |=> ctrl_ff.abort_motion_pulse && state_ff == ST_STOPPING)
        else $error("abort with report did not stop first");

    a_reach_after_stop: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && state_ff == ST_STOPPING && motor_stopped) |=> target_reached_output)
        else $error("target reached not raised after stop");

    a_standstill_gate: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && motor_speed >= zero_speed_threshold) |=> !ctrl_ff.standstill_hold)
        else $error("standstill lock above zero speed");

    a_invert_mode: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && control_mode == MODE_EXT_PULSE) |=> !ctrl_ff.direction_inverted)
        else $error("direction inverted in external pulse mode");

    a_hold_mode: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && funcs.motion_hold_input && in_int_pos) |=> ctrl_ff.position_paused)
        else $error("hold did not pause motion");

    a_torque_mode: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && in_torque) |=> !ctrl_ff.torque_limit_active)
        else $error("torque limit active in torque mode");

    a_speed_limit: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !in_torque) |=> !ctrl_ff.speed_limit_active)
        else $error("speed limit active outside torque mode");

endmodule
`default_nettype wire

/* rtl/servo_input_pkg.sv */
// Shared constants and types for the digital input function decoder
package servo_input_pkg;

    // Function codes assigned to digital input lines
    localparam logic [3:0] FN_DRIVE_ENABLE  = 4'h1;
    localparam logic [3:0] FN_FAULT_CLEAR   = 4'h2;
    localparam logic [3:0] FN_GAIN_BOOST    = 4'h3;
    localparam logic [3:0] FN_DEV_CLEAR     = 4'h4;
    localparam logic [3:0] FN_STANDSTILL    = 4'h5;
    localparam logic [3:0] FN_DIR_INVERT    = 4'h6;
    localparam logic [3:0] FN_MOTION_HOLD   = 4'h7;
    localparam logic [3:0] FN_MOVE_TRIGGER  = 4'h8;
    localparam logic [3:0] FN_TORQUE_LIMIT  = 4'h9;
    localparam logic [3:0] FN_SPEED_LIMIT   = 4'ha;
    localparam logic [3:0] FN_POS_SEL0      = 4'hb;
    localparam logic [3:0] FN_POS_SEL1      = 4'hc;
    localparam logic [3:0] FN_POS_SEL2      = 4'hd;

    localparam int         NUM_INPUTS       = 8;
    localparam int         NUM_POSITIONS    = 8;
    localparam logic [1:0] GAIN_SWITCH_ON   = 2'h1;

    // Input filter: time in ns and derived count at 100 MHz
    localparam int         CLK_PERIOD_NS    = 10;
    localparam int         FILTER_TIME_NS   = 100;
    localparam int         FILTER_CYCLES    = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] FILTER_CNT_MAX   = 4'(FILTER_CYCLES - 1);

    localparam logic [3:0] FUNC_CODE_RESET  = 4'h0;
    localparam logic       FLAG_RESET       = 1'b0;

    typedef enum logic [2:0]
    {
        MODE_EXT_PULSE = 3'b000,
        MODE_INT_POS   = 3'b001,
        MODE_SPEED     = 3'b010,
        MODE_TORQUE    = 3'b011
    } control_mode_type;

    typedef enum logic [1:0]
    {
        CLR_DEVIATION = 2'b00,
        CLR_FEEDBACK  = 2'b01,
        CLR_ABORT     = 2'b10,
        CLR_ABORT_REPORT = 2'b11
    } clear_mode_type;

    typedef struct packed
    {
        logic drive_enable_input;
        logic fault_clear_input;
        logic gain_boost_input;
        logic deviation_clear_input;
        logic standstill_lock_input;
        logic direction_invert_input;
        logic motion_hold_input;
        logic move_trigger_input;
        logic torque_limit_enable_input;
        logic speed_limit_enable_input;
        logic position_select_bit0;
        logic position_select_bit1;
        logic position_select_bit2;
    } input_funcs_type;

    typedef struct packed
    {
        logic       servo_ready;
        logic       fault_clear_pulse;
        logic       gain_boosted;
        logic       deviation_reset_pulse;
        logic       feedback_reset_pulse;
        logic       abort_motion_pulse;
        logic       standstill_hold;
        logic       direction_inverted;
        logic       position_paused;
        logic       move_start_pulse;
        logic [2:0] move_index;
        logic       torque_limit_active;
        logic       torque_limit_from_analog;
        logic       speed_limit_active;
        logic       speed_limit_from_analog;
    } motion_ctrl_type;

    // Returns the function code of one input line
    function automatic logic [3:0] code_of(input logic [31:0] codes, input int idx);
        return codes[idx*4 +: 4];
    endfunction

endpackage

/* rtl/input_filter.sv */
// Two-flop synchroniser followed by a stability filter for one input line
`timescale 1ns/1ps
`default_nettype none
module input_filter
    import servo_input_pkg::*;
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic raw_in,
    output var  logic clean_out
);

    logic       sync1_ff;
    logic       sync2_ff;
    logic [3:0] cnt_ff;
    logic       clean_ff;
    logic [3:0] nxt_cnt;
    logic       nxt_clean;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_cnt   = cnt_ff;
        nxt_clean = clean_ff;
        // Changes must persist a full filter time, so a bounce never passes
        if (sync2_ff == clean_ff)
        begin
            nxt_cnt = 4'h0;
        end
        else if (cnt_ff == FILTER_CNT_MAX)
        begin
            nxt_cnt   = 4'h0;
            nxt_clean = sync2_ff;
        end
        else
        begin
            nxt_cnt = cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_ff <= FLAG_RESET;
            sync2_ff <= FLAG_RESET;
            cnt_ff   <= 4'h0;
            clean_ff <= FLAG_RESET;
        end
        else if (clk_en)
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            cnt_ff   <= nxt_cnt;
            clean_ff <= nxt_clean;
        end
    end

    assign clean_out = clean_ff;

    a_filter_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && clean_ff != sync2_ff && cnt_ff != FILTER_CNT_MAX)
            |=> $stable(clean_ff))
        else $error("filtered input changed before filter time");

endmodule
`default_nettype wire

/* rtl/func_decoder.sv */
// Maps filtered input lines onto functions by their assigned codes
`timescale 1ns/1ps
`default_nettype none
module func_decoder
    import servo_input_pkg::*;
(
    input  wire logic [NUM_INPUTS-1:0]   lines,
    input  wire logic [NUM_INPUTS*4-1:0] codes,
    output var  input_funcs_type         funcs
);

    // Several lines may share a code; they are ORed together
    function automatic logic any_with(input logic [3:0] fn, input logic [NUM_INPUTS-1:0] l,
                                      input logic [31:0] c);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            hit = hit | (l[i] && code_of(c, i) == fn);
        end
        return hit;
    endfunction

    always_comb
    begin
        funcs.drive_enable_input        = any_with(FN_DRIVE_ENABLE, lines, codes);
        funcs.fault_clear_input         = any_with(FN_FAULT_CLEAR, lines, codes);
        funcs.gain_boost_input          = any_with(FN_GAIN_BOOST, lines, codes);
        funcs.deviation_clear_input     = any_with(FN_DEV_CLEAR, lines, codes);
        funcs.standstill_lock_input     = any_with(FN_STANDSTILL, lines, codes);
        funcs.direction_invert_input    = any_with(FN_DIR_INVERT, lines, codes);
        funcs.motion_hold_input         = any_with(FN_MOTION_HOLD, lines, codes);
        funcs.move_trigger_input        = any_with(FN_MOVE_TRIGGER, lines, codes);
        funcs.torque_limit_enable_input = any_with(FN_TORQUE_LIMIT, lines, codes);
        funcs.speed_limit_enable_input  = any_with(FN_SPEED_LIMIT, lines, codes);
        funcs.position_select_bit0      = any_with(FN_POS_SEL0, lines, codes);
        funcs.position_select_bit1      = any_with(FN_POS_SEL1, lines, codes);
        funcs.position_select_bit2      = any_with(FN_POS_SEL2, lines, codes);
    end

endmodule
`default_nettype wire

/* verif/motion_host_model.sv */
// Behavioural model of the external controller driving the digital input lines
`timescale 1ns/1ps
`default_nettype none
module motion_host_model
(
    input  wire logic       clock,
    output var  logic [7:0] lines
);
    initial lines = 8'h00;

    // Lines change only at the falling edge, well clear of the sampling edge
    task automatic set_line(input int i, input logic v);
        @(negedge clock);
        lines[i] = v;
    endtask

    // Select lines settle long before the trigger and stay through it
    task automatic trigger_move(input logic [2:0] idx);
        @(negedge clock);
        lines[3:1] = idx;
        repeat (20) @(negedge clock);
        lines[4] = 1'b1;
        repeat (40) @(negedge clock);
        lines[4] = 1'b0;
        repeat (20) @(negedge clock);
    endtask
endmodule
`default_nettype wire

/* verif/tb_servo_digital_input_functions.sv */
// Self-checking bench for the digital input function unit
`timescale 1ns/1ps
`default_nettype none
module tb_servo_digital_input_functions;
    import servo_input_pkg::*;
    typedef struct
    {
        control_mode_type m;
        logic [3:0]       c;
        logic             so;
        logic [15:0]      spd;
        logic             src;
        logic [16:0]      e;
    } row_type;
    logic clock, sys_rst, clk_en, servo_on_setting, motor_stopped, fault_latched, fault_clearable;
    logic [3:0] code0;
    logic src;
    logic [7:0] input_lines;
    logic [15:0] motor_speed;
    control_mode_type control_mode;
    clear_mode_type clear_mode_setting;
    motion_ctrl_type ctrl;
    logic fault_active, target_reached_output;
    logic [7:0] pc [5];
    int n_fail = 0;
    int checks = 0;
    row_type rows [16] = '{
        '{MODE_INT_POS, 4'h1, 1'b1, 16'h0, 1'b0, 17'h10000},
        '{MODE_INT_POS, 4'h1, 1'b0, 16'h0, 1'b0, 17'h00000},
        '{MODE_SPEED, 4'h3, 1'b1, 16'h0, 1'b0, 17'h04000},
        '{MODE_INT_POS, 4'h3, 1'b1, 16'h0, 1'b0, 17'h04000},
        '{MODE_TORQUE, 4'h3, 1'b1, 16'h0, 1'b0, 17'h00000},
        '{MODE_SPEED, 4'h5, 1'b1, 16'h0, 1'b0, 17'h00400},
        '{MODE_SPEED, 4'h5, 1'b1, 16'h10, 1'b0, 17'h00000},
        '{MODE_INT_POS, 4'h6, 1'b1, 16'h0, 1'b0, 17'h00200},
        '{MODE_TORQUE, 4'h6, 1'b1, 16'h0, 1'b0, 17'h00200},
        '{MODE_EXT_PULSE, 4'h6, 1'b1, 16'h0, 1'b0, 17'h00000},
        '{MODE_INT_POS, 4'h7, 1'b1, 16'h0, 1'b0, 17'h00100},
        '{MODE_SPEED, 4'h7, 1'b1, 16'h0, 1'b0, 17'h00000},
        '{MODE_SPEED, 4'h9, 1'b1, 16'h0, 1'b1, 17'h0000d},
        '{MODE_TORQUE, 4'h9, 1'b1, 16'h0, 1'b0, 17'h00000},
        '{MODE_TORQUE, 4'ha, 1'b1, 16'h0, 1'b1, 17'h00007},
        '{MODE_SPEED, 4'ha, 1'b1, 16'h0, 1'b0, 17'h00000}};

    servo_digital_input_functions servo_digital_input_functions_inst
    (
        .clock                 (clock),
        .sys_rst               (sys_rst),
        .clk_en                (clk_en),
        .input_lines           (input_lines),
        .input_codes           ({4'h1, 4'h4, 4'h2, 4'h8, 4'hd, 4'hc, 4'hb, code0}),
        .control_mode          (control_mode),
        .clear_mode_setting    (clear_mode_setting),
        .gain_switch_setting   (GAIN_SWITCH_ON),
        .servo_on_setting      (servo_on_setting),
        .zero_speed_threshold  (16'h0005),
        .motor_speed           (motor_speed),
        .motor_stopped         (motor_stopped),
        .fault_latched         (fault_latched),
        .fault_clearable       (fault_clearable),
        .torque_source_analog  (src),
        .speed_source_analog   (src),
        .ctrl                  (ctrl),
        .fault_active          (fault_active),
        .target_reached_output (target_reached_output)
    );
    motion_host_model motion_host_model_inst
    (
        .clock (clock),
        .lines (input_lines)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Pulse counters: one-cycle outputs are easy to miss by sampling alone
    always @(posedge clock)
    begin
        pc[0] <= pc[0] + 8'(ctrl.move_start_pulse);
        pc[1] <= pc[1] + 8'(ctrl.deviation_reset_pulse);
        pc[2] <= pc[2] + 8'(ctrl.feedback_reset_pulse);
        pc[3] <= pc[3] + 8'(ctrl.abort_motion_pulse);
        pc[4] <= pc[4] + 8'(ctrl.fault_clear_pulse);
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic clr_pc();
        @(negedge clock);
        foreach (pc[i]) pc[i] <= 8'h00;
    endtask
    task automatic chk(input string nm, input logic [16:0] ex, input logic [16:0] got);
        checks++;
        if (got !== ex)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic pulse_line(input int i, input int n);
        motion_host_model_inst.set_line(i, 1'b1);
        wt(n);
        motion_host_model_inst.set_line(i, 1'b0);
        wt(20);
    endtask
    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        servo_on_setting = 1'b1;
        motor_stopped = 1'b0;
        fault_latched = 1'b0;
        fault_clearable = 1'b0;
        code0 = 4'h5;
        src = 1'b0;
        motor_speed = 16'h0;
        control_mode = MODE_INT_POS;
        clear_mode_setting = CLR_DEVIATION;
        wt(5);
        chk("reset ctrl", 17'h0, ctrl);
        sys_rst = 1'b0;
        wt(2);
        $display("reset test done");
        foreach (rows[r])
        begin
            control_mode = rows[r].m;
            {code0, servo_on_setting} = {rows[r].c, rows[r].so};
            {motor_speed, src} = {rows[r].spd, rows[r].src};
            wt(3);
            motion_host_model_inst.set_line(0, 1'b1);
            wt(20);
            chk("ctrl row", rows[r].e, ctrl);
            motion_host_model_inst.set_line(0, 1'b0);
            wt(20);
        end
        $display("table test done");
        // Glitch shorter than the filter must vanish
        control_mode = MODE_SPEED;
        {code0, motor_speed, src} = {4'h5, 16'h0, 1'b0};
        motion_host_model_inst.set_line(0, 1'b1);
        wt(5);
        chk("glitch", 17'h0, ctrl);
        pulse_line(0, 1);
        chk("glitch", 17'h0, ctrl);
        $display("filter test done");
        for (int cm = 0; cm < 4; cm++)
        begin
            control_mode = MODE_INT_POS;
            clear_mode_setting = clear_mode_type'(cm);
            motor_stopped = 1'b0;
            clr_pc();
            pulse_line(6, 30);
            chk("dev clr", 17'(cm == 0), pc[1]);
            chk("fb clr", 17'(cm == 1), pc[2]);
            chk("abort", 17'(cm >= 2), pc[3]);
            chk("tgt busy", 17'h0, target_reached_output);
            motor_stopped = 1'b1;
            wt(5);
            chk("tgt", 17'(cm == 3), target_reached_output);
        end
        control_mode = MODE_SPEED;
        for (int cm = 0; cm < 4; cm++)
        begin
            clear_mode_setting = clear_mode_type'(cm);
            clr_pc();
            pulse_line(6, 30);
            chk("clear off", 17'h0, 17'(pc[1] | pc[2] | pc[3]));
        end
        control_mode = MODE_EXT_PULSE;
        clear_mode_setting = CLR_ABORT;
        clr_pc();
        pulse_line(6, 30);
        chk("abort ext", 17'h0, pc[3]);
        clear_mode_setting = CLR_FEEDBACK;
        clr_pc();
        pulse_line(6, 30);
        chk("fb ext", 17'h1, pc[2]);
        $display("clear test done");
        control_mode = MODE_INT_POS;
        for (int k = 5; k >= 2; k -= 3)
        begin
            clr_pc();
            motion_host_model_inst.trigger_move(3'(k));
            chk("starts", 17'h1, pc[0]);
            chk("index", 17'(k), ctrl.move_index);
            chk("tgt clr", 17'h0, target_reached_output);
        end
        control_mode = MODE_SPEED;
        clr_pc();
        motion_host_model_inst.trigger_move(3'h7);
        chk("starts off", 17'h0, pc[0]);
        $display("trigger test done");
        fault_latched = 1'b1;
        wt(1);
        fault_latched = 1'b0;
        wt(3);
        chk("fault", 17'h1, fault_active);
        clr_pc();
        pulse_line(5, 30);
        chk("fault kept", 17'h1, fault_active);
        fault_clearable = 1'b1;
        pulse_line(5, 30);
        chk("fault clr", 17'h0, fault_active);
        // Clear stands while the filtered line is high: 31 cycles
        chk("clr pulses", 17'h1f, pc[4]);
        $display("fault test done");
        // Low enable must freeze the filters and outputs
        clk_en = 1'b0;
        motion_host_model_inst.set_line(0, 1'b1);
        wt(20);
        chk("frozen", 17'h0, ctrl.standstill_hold);
        clk_en = 1'b1;
        wt(20);
        chk("thawed", 17'h1, ctrl.standstill_hold);
        motion_host_model_inst.set_line(0, 1'b0);
        $display("enable test done");
        end_sim();
    end
endmodule
`default_nettype wire
